// ==== src/edge_stamp_regs.vh ====
// Register map, reset values and timing counts of the edge timestamp reporter
`ifndef EDGE_STAMP_REGS_VH
`define EDGE_STAMP_REGS_VH

// Byte offsets
`define CTRL_OFF 8'h00
`define INTERVAL_OFF 8'h04
`define FILTER_OFF 8'h08
`define RISE_SEL_OFF 8'h0c
`define FALL_SEL_OFF 8'h10
`define INPUT_OFF 8'h14
`define STATUS_OFF 8'h18
`define MASK_OFF 8'h1c
`define POINT_SEL_OFF 8'h20
`define STAMP_OFF 8'h24
`define LAST_OFF 8'h28

// Control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_RESET 2'h1

// Status fields
`define STAT_CYCLIC_BIT 0
`define STAT_EDGE_BIT 1

// Times in microseconds; clock frequency in MHz
`define INTERVAL_MIN_US 20'h000fa
`define INTERVAL_MAX_US 20'hb71b0
`define INTERVAL_RESET_US 20'h02710
`define FILTER_MAX_US 16'hc350
`define SCAN_US 5'h19
`define CLK_MHZ 8'h14
// Cycles in one microsecond at 20 MHz
`define US_CYCLES 5'h14

// Both edges selected on every point after reset
`define SEL_RESET 16'hffff

`endif

// ==== src/input_filter.v ====
// Per-point input filter with a delay in microseconds
`timescale 1ns/1ps
module input_filter (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Timing
	input wire tick_us,
	input wire [15:0] delay_us,
	// Data
	input wire [15:0] raw_in,
	output reg [15:0] filt_out
);

genvar i;
generate
	for (i = 0; i < 16; i = i + 1) begin : g_pt
		reg [15:0] cnt_reg;
		always @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				cnt_reg <= 16'h0000;
				filt_out[i] <= 1'b0;
			end else if (raw_in[i] == filt_out[i]) begin
				cnt_reg <= 16'h0000;
			end else if (cnt_reg >= delay_us) begin
				// Change accepted only after staying stable for the delay
				filt_out[i] <= raw_in[i];
				cnt_reg <= 16'h0000;
			end else if (tick_us) begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end
endgenerate

endmodule

// ==== src/interval_timer.v ====
// Cyclic report interval timer counting microsecond ticks
`timescale 1ns/1ps
`include "edge_stamp_regs.vh"
module interval_timer (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Control
	input wire tick_us,
	input wire run,
	input wire restart,
	input wire [19:0] interval_us,
	// Event
	output reg elapsed
);

reg [19:0] cnt_reg;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		cnt_reg <= 20'h00000;
		elapsed <= 1'b0;
	end else begin
		elapsed <= 1'b0;
		if (restart || !run) begin
			cnt_reg <= 20'h00000;
		end else if (tick_us) begin
			if (cnt_reg >= interval_us - 20'h00001) begin
				cnt_reg <= 20'h00000;
				elapsed <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 20'h00001;
			end
		end
	end
end

endmodule

// ==== src/edge_stamp_reporter.v ====
// Sixteen-point input edge timestamp reporter with AHB-Lite registers
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "edge_stamp_regs.vh"

// Functional notes
// - Send input data each time the report interval elapses.
// - Report interval is programmable from 250 us to 750 ms.
// - Per point, capture rising only, falling only, or both edges.
// - Enabled edge latches system time and sends data at once.
// - After reset every point captures both rising and falling edges.
// - An interval is always in force; its default is 10 ms.
// - Each input filter delays recognition by zero up to 50 ms.
// - Input scan adds at most 25 us of sampling latency.
// - With zero filter, a change reaches the report within its bound.
// - Event queue and per-point modes report different data sets.
// - Only edge-triggered reports raise the event trigger.
module edge_stamp_reporter (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Field inputs and time base
	input wire [15:0] field_in,
	input wire [31:0] system_time_stamp,
	// Report to the owner controller
	output reg report_valid,
	output reg report_edge,
	output reg event_trigger,
	output reg report_mode,
	output reg [15:0] report_inputs,
	output reg [15:0] report_changed,
	output reg [3:0] report_point,
	output reg [31:0] report_stamp,
	// Interrupt
	output reg irq
);

////////////////////////////////////////////////////////////////////////
// Registers

reg [1:0] ctrl_reg;
reg [19:0] report_interval_reg;
reg [15:0] filter_reg;
reg [15:0] rise_sel_reg;
reg [15:0] fall_sel_reg;
reg [1:0] status_reg;
reg [1:0] mask_reg;
reg [3:0] point_sel_reg;
reg [31:0] stamp_reg [0:15];
reg [15:0] pend_reg;
reg [3:0] last_point_reg;
reg [31:0] last_stamp_reg;

reg wr_pend_reg;
reg [7:0] wr_addr_reg;

reg [4:0] us_cnt_reg;
reg tick_us_reg;
reg [4:0] scan_cnt_reg;
reg [15:0] sample_reg;
reg [15:0] prev_reg;
reg interval_restart_reg;

wire [15:0] filt;
wire elapsed;
wire per_point_stamp_mode;
wire enable;
wire [15:0] rise;
wire [15:0] fall;
wire [15:0] edge_hit;
wire addr_ok;
wire wr_now;
wire [31:0] clr_mask;

reg [3:0] first_point;
reg [31:0] rd_next;
reg [19:0] interval_next;
reg [15:0] filter_next;
integer k;

assign enable = ctrl_reg[`CTRL_ENABLE_BIT];
assign per_point_stamp_mode = ctrl_reg[`CTRL_MODE_BIT];

////////////////////////////////////////////////////////////////////////
// Time base and input scan

// One pulse per microsecond; all times count in these ticks
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		us_cnt_reg <= 5'h00;
		tick_us_reg <= 1'b0;
	end else if (us_cnt_reg == `US_CYCLES - 5'h01) begin
		us_cnt_reg <= 5'h00;
		tick_us_reg <= 1'b1;
	end else begin
		us_cnt_reg <= us_cnt_reg + 5'h01;
		tick_us_reg <= 1'b0;
	end
end

// Inputs are sampled once per scan period; latency is below one period
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		scan_cnt_reg <= 5'h00;
		sample_reg <= 16'h0000;
	end else if (tick_us_reg) begin
		if (scan_cnt_reg == `SCAN_US - 5'h01) begin
			scan_cnt_reg <= 5'h00;
			sample_reg <= field_in;
		end else begin
			scan_cnt_reg <= scan_cnt_reg + 5'h01;
		end
	end
end

input_filter u_filter (
	.hclk(hclk),
	.hresetn(hresetn),
	.tick_us(tick_us_reg),
	.delay_us(filter_reg),
	.raw_in(sample_reg),
	.filt_out(filt)
);

interval_timer u_timer (
	.hclk(hclk),
	.hresetn(hresetn),
	.tick_us(tick_us_reg),
	.run(enable),
	.restart(interval_restart_reg),
	.interval_us(report_interval_reg),
	.elapsed(elapsed)
);

////////////////////////////////////////////////////////////////////////
// Edge detection and time capture

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		prev_reg <= 16'h0000;
	end else begin
		prev_reg <= filt;
	end
end

assign rise = filt & ~prev_reg & rise_sel_reg;
assign fall = ~filt & prev_reg & fall_sel_reg;
assign edge_hit = (rise | fall) & {16{enable}};

always @* begin
	first_point = 4'h0;
	for (k = 15; k >= 0; k = k - 1) begin
		if (edge_hit[k]) begin
			first_point = k[3:0];
		end
	end
end

genvar p;
generate
	for (p = 0; p < 16; p = p + 1) begin : g_stamp
		always @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				stamp_reg[p] <= 32'h00000000;
			end else if (edge_hit[p]) begin
				stamp_reg[p] <= system_time_stamp;
			end
		end
	end
endgenerate

// Changed points since last report; edges are never lost on report
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		pend_reg <= 16'h0000;
		last_point_reg <= 4'h0;
		last_stamp_reg <= 32'h00000000;
	end else begin
		if (report_valid) begin
			pend_reg <= edge_hit;
		end else begin
			pend_reg <= pend_reg | edge_hit;
		end
		if (|edge_hit) begin
			last_point_reg <= first_point;
			last_stamp_reg <= system_time_stamp;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Report production

// Edge and cyclic causes in one cycle merge into one edge report
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		report_valid <= 1'b0;
		report_edge <= 1'b0;
		event_trigger <= 1'b0;
		report_mode <= 1'b0;
		report_inputs <= 16'h0000;
		report_changed <= 16'h0000;
		report_point <= 4'h0;
		report_stamp <= 32'h00000000;
	end else begin
		report_valid <= elapsed | (|edge_hit);
		report_edge <= |edge_hit;
		event_trigger <= |edge_hit;
		if (elapsed | (|edge_hit)) begin
			report_mode <= per_point_stamp_mode;
			report_inputs <= filt;
			if (per_point_stamp_mode) begin
				// Per-point set: all changed points and selected stamp
				report_changed <= pend_reg | edge_hit;
				report_point <= point_sel_reg;
				report_stamp <= edge_hit[point_sel_reg] ?
					system_time_stamp : stamp_reg[point_sel_reg];
			end else begin
				// Queue set: the newest single event entry
				report_changed <= edge_hit;
				report_point <= (|edge_hit) ? first_point :
					last_point_reg;
				report_stamp <= (|edge_hit) ? system_time_stamp :
					last_stamp_reg;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// AHB-Lite slave

assign addr_ok = hsel & hready & htrans[1];
assign wr_now = wr_pend_reg;
assign clr_mask = (wr_now && wr_addr_reg == `STATUS_OFF) ?
	hwdata : 32'h00000000;

// Out-of-range interval values clamp to the legal span
always @* begin
	if (hwdata[19:0] < `INTERVAL_MIN_US) begin
		interval_next = `INTERVAL_MIN_US;
	end else if (hwdata > {12'h000, `INTERVAL_MAX_US}) begin
		interval_next = `INTERVAL_MAX_US;
	end else begin
		interval_next = hwdata[19:0];
	end
	if (hwdata > {16'h0000, `FILTER_MAX_US}) begin
		filter_next = `FILTER_MAX_US;
	end else begin
		filter_next = hwdata[15:0];
	end
end

always @* begin
	case (haddr)
	`CTRL_OFF: rd_next = {30'h0, ctrl_reg};
	`INTERVAL_OFF: rd_next = {12'h000, report_interval_reg};
	`FILTER_OFF: rd_next = {16'h0000, filter_reg};
	`RISE_SEL_OFF: rd_next = {16'h0000, rise_sel_reg};
	`FALL_SEL_OFF: rd_next = {16'h0000, fall_sel_reg};
	`INPUT_OFF: rd_next = {16'h0000, filt};
	`STATUS_OFF: rd_next = {30'h0, status_reg};
	`MASK_OFF: rd_next = {30'h0, mask_reg};
	`POINT_SEL_OFF: rd_next = {28'h0000000, point_sel_reg};
	`STAMP_OFF: rd_next = stamp_reg[point_sel_reg];
	`LAST_OFF: rd_next = {28'h0000000, last_point_reg};
	default: rd_next = 32'h00000000;
	endcase
end

// Zero wait states: reads are fetched in the address phase
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h00000000;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wr_pend_reg <= 1'b0;
		wr_addr_reg <= 8'h00;
	end else begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wr_pend_reg <= addr_ok & hwrite;
		if (addr_ok) begin
			wr_addr_reg <= haddr;
		end
		if (addr_ok && !hwrite) begin
			hrdata <= rd_next;
		end
	end
end

// Register writes in the data phase
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		ctrl_reg <= `CTRL_RESET;
		report_interval_reg <= `INTERVAL_RESET_US;
		filter_reg <= 16'h0000;
		rise_sel_reg <= `SEL_RESET;
		fall_sel_reg <= `SEL_RESET;
		mask_reg <= 2'h0;
		point_sel_reg <= 4'h0;
		interval_restart_reg <= 1'b0;
	end else begin
		interval_restart_reg <= 1'b0;
		if (wr_now) begin
			case (wr_addr_reg)
			`CTRL_OFF: ctrl_reg <= hwdata[1:0];
			`INTERVAL_OFF: begin
				report_interval_reg <= interval_next;
				interval_restart_reg <= 1'b1;
			end
			`FILTER_OFF: filter_reg <= filter_next;
			`RISE_SEL_OFF: rise_sel_reg <= hwdata[15:0];
			`FALL_SEL_OFF: fall_sel_reg <= hwdata[15:0];
			`MASK_OFF: mask_reg <= hwdata[1:0];
			`POINT_SEL_OFF: point_sel_reg <= hwdata[3:0];
			default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Status and interrupt

// Set beats a same-cycle write-one clear so no event is lost
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		status_reg <= 2'h0;
		irq <= 1'b0;
	end else begin
		status_reg[`STAT_CYCLIC_BIT] <= elapsed |
			(status_reg[`STAT_CYCLIC_BIT] &
			~clr_mask[`STAT_CYCLIC_BIT]);
		status_reg[`STAT_EDGE_BIT] <= (|edge_hit) |
			(status_reg[`STAT_EDGE_BIT] &
			~clr_mask[`STAT_EDGE_BIT]);
		irq <= |(status_reg & mask_reg);
	end
end

endmodule

// ==== dv/owner_controller_model.sv ====
// Owner controller model consuming reports from the reporter
`timescale 1ns/1ps
module owner_controller_model (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Reports
	input wire report_valid,
	input wire event_trigger,
	input wire [15:0] report_inputs,
	// Scan copy and trigger tally
	output reg [15:0] scan_copy,
	output reg [15:0] trig_count
);
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		scan_copy <= 16'h0;
		trig_count <= 16'h0;
	end else begin
		// Copy at arrival so a scan never sees a half update
		if (report_valid)
			scan_copy <= report_inputs;
		// Sole consumer of this module's triggers
		if (event_trigger)
			trig_count <= trig_count + 16'h1;
	end
end
endmodule

// ==== dv/edge_stamp_props.sv ====
// Assertions on the edge timestamp reporter ports
`timescale 1ns/1ps
module edge_stamp_props (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Bus
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	// Report
	input wire report_valid,
	input wire report_edge,
	input wire event_trigger,
	input wire [15:0] report_inputs,
	input wire irq
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
wire take_wr = hsel && hready && htrans[1] && hwrite;
wire take_rd = hsel && hready && htrans[1] && !hwrite;
// Saturates so a long quiet spell cannot wrap into a short gap
reg [23:0] gap_reg;
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn)
		gap_reg <= 24'h0;
	else if (report_valid && !report_edge)
		gap_reg <= 24'h0;
	else if (gap_reg != 24'hffffff)
		gap_reg <= gap_reg + 24'h1;
end
a_trig_edge: assert property (event_trigger == report_edge)
	else $error("trigger differs from edge flag");
a_edge_valid: assert property (report_edge |-> report_valid)
	else $error("edge flag without report");
a_cyclic_gap: assert property (
	report_valid && !report_edge |-> gap_reg >= 24'h1387)
	else $error("cyclic reports too close");
a_bus_okay: assert property (!hresp)
	else $error("error response");
a_zero_wait: assert property (hreadyout)
	else $error("wait state");
a_unmapped_zero: assert property (
	take_rd && haddr == 8'h30 |=> hrdata == 32'h0)
	else $error("unmapped read not zero");
a_irq_cause: assert property ($rose(irq) |->
	$past(report_valid) || $past(take_wr, 2) || $past(take_wr, 3))
	else $error("interrupt without cause");
a_data_hold: assert property (!report_valid |-> $stable(report_inputs))
	else $error("report data moved between reports");
c_edge: cover property (report_edge);
c_cyclic: cover property (report_valid && !report_edge);
c_irq: cover property ($rose(irq));
endmodule

bind edge_stamp_reporter edge_stamp_props chk_u (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .report_valid(report_valid),
	.report_edge(report_edge), .event_trigger(event_trigger),
	.report_inputs(report_inputs), .irq(irq));

// ==== dv/edge_stamp_reporter_tb.sv ====
// Testbench for the edge timestamp reporter
`timescale 1ns/1ps
`include "edge_stamp_regs.vh"
module edge_stamp_reporter_tb;
reg hclk, hresetn, hsel, hwrite;
reg [7:0] haddr;
reg [1:0] htrans;
reg [2:0] hsize;
reg [31:0] hwdata, system_time_stamp, rd;
reg [15:0] field_in;
wire [31:0] hrdata, report_stamp;
wire hreadyout, hresp, report_valid, report_edge, event_trigger;
wire report_mode, irq;
wire [15:0] report_inputs, report_changed, scan_copy, trig_count;
wire [3:0] report_point;
integer failures, checked, cycles, expd;

edge_stamp_reporter dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .field_in(field_in),
	.system_time_stamp(system_time_stamp), .report_valid(report_valid),
	.report_edge(report_edge), .event_trigger(event_trigger),
	.report_mode(report_mode), .report_inputs(report_inputs),
	.report_changed(report_changed), .report_point(report_point),
	.report_stamp(report_stamp), .irq(irq));
owner_controller_model ctrl_u (.hclk(hclk), .hresetn(hresetn),
	.report_valid(report_valid), .event_trigger(event_trigger),
	.report_inputs(report_inputs), .scan_copy(scan_copy),
	.trig_count(trig_count));

////////////////////////////////////////////////////////////////////////
initial begin
	hclk = 1'b0;
	forever #25 hclk = ~hclk;
end
always @(posedge hclk) begin
	system_time_stamp <= system_time_stamp + 32'h1;
	cycles = cycles + 1;
	if (cycles == 90000) begin
		failures = failures + 1;
		conclude;
	end
end

task conclude;
	$display("checked %0d failures %0d", checked, failures);
	if (failures == 0 && checked > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask

task chk(input ok);
	checked = checked + 1;
	if (ok !== 1'b1) begin
		failures = failures + 1;
		$display("unexpected at %0t: check %0d", $time, checked);
	end
endtask

// Single word transfer; read data lands in rd
task bus(input [7:0] a, input w, input [31:0] d);
	@(posedge hclk);
	hsel <= 1'b1;
	haddr <= a;
	htrans <= 2'h2;
	hwrite <= w;
	do @(posedge hclk); while (hreadyout !== 1'b1);
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= d;
	do @(posedge hclk); while (hreadyout !== 1'b1);
	rd = hrdata;
endtask

task rdc(input [7:0] a, input [31:0] e);
	bus(a, 1'b0, 32'h0);
	chk(rd === e);
endtask

// Moves one field input and waits up to hi cycles for an edge report
task fire(input [3:0] p, input v, input e, input integer lo, hi);
	integer n;
	reg [31:0] t0;
	reg hit;
	@(posedge hclk);
	field_in[p] <= v;
	t0 = system_time_stamp;
	n = 0;
	hit = 1'b0;
	while (n < hi && !hit) begin
		@(posedge hclk);
		#1 hit = report_edge;
		n = n + 1;
	end
	chk(hit === e);
	if (e) begin
		expd = expd + 1;
		chk(n >= lo && report_inputs[p] === v && event_trigger);
		chk(report_stamp >= t0 && report_stamp <= system_time_stamp);
	end
endtask

////////////////////////////////////////////////////////////////////////
task t_defaults;
	chk(report_valid === 1'b0 && irq === 1'b0 && hreadyout === 1'b1);
	chk(hresp === 1'b0 && report_inputs === 16'h0);
	rdc(`CTRL_OFF, 32'h1);
	rdc(`INTERVAL_OFF, 32'h2710);
	rdc(`RISE_SEL_OFF, 32'hffff);
	rdc(`FALL_SEL_OFF, 32'hffff);
	rdc(`FILTER_OFF, 32'h0);
	bus(8'h30, 1'b1, 32'hffffffff);
	rdc(8'h30, 32'h0);
	bus(`INTERVAL_OFF, 1'b1, 32'h1);
	rdc(`INTERVAL_OFF, 32'hfa);
	bus(`INTERVAL_OFF, 1'b1, 32'hc3500);
	rdc(`INTERVAL_OFF, 32'hb71b0);
endtask

task t_cyclic;
	integer n, k;
	bus(`INTERVAL_OFF, 1'b1, 32'hfa);
	for (k = 0; k < 2; k = k + 1) begin
		n = 0;
		@(posedge hclk);
		#1;
		while (n < 5200 && !(report_valid === 1'b1 && !report_edge)) begin
			@(posedge hclk);
			#1;
			n = n + 1;
		end
		chk(k == 0 ? n < 5200 : n == 4999);
		chk(report_mode === 1'b0);
	end
	// Longest interval keeps cyclic reports out of the edge checks
	bus(`INTERVAL_OFF, 1'b1, 32'hb71b0);
endtask

task t_select;
	// Scan of 500 cycles plus a short pipeline, well inside the bound
	fire(4'h0, 1'b1, 1'b1, 0, 520);
	chk(report_point === 4'h0);
	bus(`RISE_SEL_OFF, 1'b1, 32'h1);
	bus(`FALL_SEL_OFF, 1'b1, 32'h2);
	fire(4'h0, 1'b0, 1'b0, 0, 5600);
	fire(4'h0, 1'b1, 1'b1, 0, 5500);
	fire(4'h1, 1'b1, 1'b0, 0, 5600);
	fire(4'h1, 1'b0, 1'b1, 0, 5500);
	chk(report_point === 4'h1);
endtask

task t_filter;
	bus(`FILTER_OFF, 1'b1, 32'hffff);
	rdc(`FILTER_OFF, 32'hc350);
	bus(`RISE_SEL_OFF, 1'b1, 32'hffff);
	bus(`FILTER_OFF, 1'b1, 32'h64);
	fire(4'h1, 1'b1, 1'b1, 2000, 7500);
	bus(`FILTER_OFF, 1'b1, 32'h0);
endtask

task t_irq;
	chk(irq === 1'b0);
	bus(`STATUS_OFF, 1'b1, 32'h3);
	bus(`MASK_OFF, 1'b1, 32'h2);
	rdc(`MASK_OFF, 32'h2);
	fire(4'h2, 1'b1, 1'b1, 0, 5500);
	@(posedge hclk);
	#1 chk(irq === 1'b1);
	rdc(`STATUS_OFF, 32'h2);
	bus(`STATUS_OFF, 1'b1, 32'h2);
	@(posedge hclk);
	#1 chk(irq === 1'b0);
endtask

task t_perpoint;
	// Disabled block must neither capture nor report an edge
	bus(`CTRL_OFF, 1'b1, 32'h0);
	fire(4'h3, 1'b1, 1'b0, 0, 600);
	bus(`FALL_SEL_OFF, 1'b1, 32'hffff);
	bus(`CTRL_OFF, 1'b1, 32'h3);
	fire(4'h0, 1'b0, 1'b1, 0, 14500);
	chk(report_mode === 1'b1 && report_changed[0] === 1'b1);
	chk(report_point === 4'h0 && report_changed[15:1] === 15'h0);
	rdc(`INPUT_OFF, 32'he);
	rdc(`LAST_OFF, 32'h0);
	bus(`POINT_SEL_OFF, 1'b1, 32'h2);
	rdc(`POINT_SEL_OFF, 32'h2);
endtask

////////////////////////////////////////////////////////////////////////
initial begin
	failures = 0;
	checked = 0;
	cycles = 0;
	expd = 0;
	hresetn = 1'b0;
	hsel = 1'b0;
	haddr = 8'h0;
	htrans = 2'h0;
	hwrite = 1'b0;
	hsize = 3'h2;
	hwdata = 32'h0;
	field_in = 16'h0;
	system_time_stamp = 32'h0;
	repeat (10) @(posedge hclk);
	hresetn <= 1'b1;
	t_defaults;
	t_cyclic;
	t_select;
	t_filter;
	t_irq;
	t_perpoint;
	repeat (2) @(posedge hclk);
	#1 chk(trig_count === expd[15:0] && scan_copy === report_inputs);
	conclude;
end
endmodule
